/* inc/erss_pkg.sv */
// Constants and types for the extended rotate / subtract / skip engine.
// Assumes a single 50 MHz core clock and a synchronous active-high reset.
package erss_pkg;

	localparam int unsigned ERSS_DATA_W = 8;
	localparam int unsigned ERSS_ADDR_W = 9;
	localparam int unsigned ERSS_MEM_DEPTH = 512;
	localparam int unsigned ERSS_PADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] ERSS_OFF_CMD = 8'h00;
	localparam logic [7:0] ERSS_OFF_ACC = 8'h04;
	localparam logic [7:0] ERSS_OFF_FLAGS = 8'h08;
	localparam logic [7:0] ERSS_OFF_STATE = 8'h0C;
	localparam logic [7:0] ERSS_OFF_PC = 8'h10;
	localparam logic [7:0] ERSS_OFF_MADDR = 8'h14;
	localparam logic [7:0] ERSS_OFF_MDATA = 8'h18;

	// Command word fields
	localparam int unsigned ERSS_CMD_OP_LSB = 0;
	localparam int unsigned ERSS_CMD_BIT_LSB = 4;
	localparam int unsigned ERSS_CMD_ADDR_LSB = 8;

	// State word fields
	localparam int unsigned ERSS_ST_BUSY = 0;
	localparam int unsigned ERSS_ST_SKIP = 1;
	localparam int unsigned ERSS_ST_CYC_LSB = 4;

	// Reset values
	localparam logic [7:0] ERSS_ACC_RST = 8'h00;
	localparam logic [5:0] ERSS_FLAGS_RST = 6'h00;
	localparam logic [15:0] ERSS_PC_RST = 16'h0000;
	localparam logic [8:0] ERSS_MADDR_RST = 9'h000;

	// Instruction cycles of a plain and of a skipping instruction
	localparam logic [1:0] ERSS_CYC_PLAIN = 2'h1;
	localparam logic [1:0] ERSS_CYC_SKIP = 2'h2;

	typedef enum logic [3:0] {
		ERSS_OP_ROTL_CARRY_TO_ACC = 4'b0000,
		ERSS_OP_ROTATE_RIGHT_MEM = 4'b0001,
		ERSS_OP_ROTATE_RIGHT_TO_ACC = 4'b0010,
		ERSS_OP_ROTR_CARRY_MEM = 4'b0011,
		ERSS_OP_ROTR_CARRY_TO_ACC = 4'b0100,
		ERSS_OP_SUB_BORROW_TO_ACC = 4'b0101,
		ERSS_OP_SUB_BORROW_TO_MEM = 4'b0110,
		ERSS_OP_DEC_SKIP_ZERO_MEM = 4'b0111,
		ERSS_OP_DEC_SKIP_ZERO_ACC = 4'b1000,
		ERSS_OP_SET_BITS_MEM = 4'b1001,
		ERSS_OP_SET_BIT_MEM = 4'b1010,
		ERSS_OP_INC_SKIP_ZERO_MEM = 4'b1011,
		ERSS_OP_INC_SKIP_ZERO_ACC = 4'b1100,
		ERSS_OP_SKIP_NONZERO_TEST = 4'b1101,
		ERSS_OP_SKIP_NONZERO_BIT = 4'b1110
	} erss_op_e;

	localparam logic [3:0] ERSS_OP_LAST = 4'hE;

	// Bit order matches the flags register: c is bit 0, cz is bit 5
	typedef struct packed {
		logic cz;
		logic sc;
		logic ov;
		logic z;
		logic ac;
		logic c;
	} erss_flags_s;

	typedef struct packed {
		erss_op_e op;
		logic [2:0] bit_sel;
		logic [8:0] addr;
	} erss_cmd_s;

	typedef struct packed {
		logic wr_mem;
		logic wr_acc;
		logic [7:0] value;
		erss_flags_s flags;
		logic skip;
	} erss_res_s;

endpackage : erss_pkg

/* logic/erss_alu.sv */
// Combinational datapath of the extended rotate / subtract / skip engine.
// Assumes operand byte, accumulator and flags are stable for the cycle.
`timescale 1ns/1ps
module erss_alu import erss_pkg::*; (
	// Instruction
	input wire erss_op_e op,
	input wire logic [2:0] bit_sel,
	// Operands
	input wire logic [7:0] mem,
	input wire logic [7:0] acc,
	input wire erss_flags_s flags,
	// Result
	output erss_res_s res
);

	logic borrow;
	logic [8:0] diff;
	logic [4:0] low_diff;
	logic [7:0] dec_val;
	logic [7:0] inc_val;
	logic [7:0] bit_mask;
	logic sub_ov;

	// Nine-bit rotate through carry: {carry out, byte}
	function automatic logic [8:0] rotr_carry(input logic [7:0] d, input logic cin);
		rotr_carry = {d[0], cin, d[7:1]};
	endfunction : rotr_carry

	assign borrow = ~flags.c;
	assign diff = {1'b0, acc} - {1'b0, mem} - {8'h00, borrow};
	assign low_diff = {1'b0, acc[3:0]} - {1'b0, mem[3:0]} - {4'h0, borrow};
	assign sub_ov = (acc[7] ^ mem[7]) & (acc[7] ^ diff[7]);
	assign dec_val = mem - 8'h01;
	assign inc_val = mem + 8'h01;
	assign bit_mask = 8'h01 << bit_sel;

	always_comb begin
		res = '0;
		res.flags = flags;
		case (op)
			ERSS_OP_ROTL_CARRY_TO_ACC: begin
				res.wr_acc = 1'b1;
				res.value = {mem[6:0], flags.c};
				res.flags.c = mem[7];
			end
			ERSS_OP_ROTATE_RIGHT_MEM: begin
				res.wr_mem = 1'b1;
				res.value = {mem[0], mem[7:1]};
			end
			ERSS_OP_ROTATE_RIGHT_TO_ACC: begin
				res.wr_acc = 1'b1;
				res.value = {mem[0], mem[7:1]};
			end
			ERSS_OP_ROTR_CARRY_MEM: begin
				res.wr_mem = 1'b1;
				{res.flags.c, res.value} = rotr_carry(mem, flags.c);
			end
			ERSS_OP_ROTR_CARRY_TO_ACC: begin
				res.wr_acc = 1'b1;
				{res.flags.c, res.value} = rotr_carry(mem, flags.c);
			end
			ERSS_OP_SUB_BORROW_TO_ACC, ERSS_OP_SUB_BORROW_TO_MEM: begin
				res.wr_acc = (op == ERSS_OP_SUB_BORROW_TO_ACC);
				res.wr_mem = (op == ERSS_OP_SUB_BORROW_TO_MEM);
				res.value = diff[7:0];
				res.flags.c = ~diff[8];
				res.flags.ac = ~low_diff[4];
				res.flags.z = (diff[7:0] == 8'h00);
				res.flags.ov = sub_ov;
				res.flags.sc = diff[7] ^ sub_ov;
				// Chained zero for multi-byte subtraction
				res.flags.cz = (diff[7:0] == 8'h00) & flags.z;
			end
			ERSS_OP_DEC_SKIP_ZERO_MEM, ERSS_OP_DEC_SKIP_ZERO_ACC: begin
				res.wr_mem = (op == ERSS_OP_DEC_SKIP_ZERO_MEM);
				res.wr_acc = (op == ERSS_OP_DEC_SKIP_ZERO_ACC);
				res.value = dec_val;
				res.skip = (dec_val == 8'h00);
			end
			ERSS_OP_SET_BITS_MEM: begin
				res.wr_mem = 1'b1;
				res.value = 8'hFF;
			end
			ERSS_OP_SET_BIT_MEM: begin
				res.wr_mem = 1'b1;
				res.value = mem | bit_mask;
			end
			ERSS_OP_INC_SKIP_ZERO_MEM, ERSS_OP_INC_SKIP_ZERO_ACC: begin
				res.wr_mem = (op == ERSS_OP_INC_SKIP_ZERO_MEM);
				res.wr_acc = (op == ERSS_OP_INC_SKIP_ZERO_ACC);
				res.value = inc_val;
				res.skip = (inc_val == 8'h00);
			end
			ERSS_OP_SKIP_NONZERO_TEST: begin
				res.skip = (mem != 8'h00);
			end
			ERSS_OP_SKIP_NONZERO_BIT: begin
				res.skip = |(mem & bit_mask);
			end
			default: begin
				res.value = 8'h00;
			end
		endcase
	end

endmodule : erss_alu

/* logic/erss_core.sv */
// Extended rotate / subtract / skip engine with data memory and APB registers.
// Assumes an APB master on CLK; one command runs at a time, software polls BUSY.
`timescale 1ns/1ps

// Function
// - Rotate left through carry into accumulator
// - Rotate memory right, bit 0 to 7
// - Rotate right into accumulator, flags kept
// - Rotate memory right through carry, carry only
// - Rotate right through carry into accumulator
// - Subtract with borrow into accumulator, flags
// - Carry clear if negative, else set
// - Subtract with borrow written to memory
// - Decrement memory, skip when zero
// - Decrement into accumulator, skip when zero
// - Skip costs two cycles, dummy inserted
// - Set whole memory byte to FFH
// - Set only the selected memory bit
// - Increment memory, skip when zero
// - Increment into accumulator, skip when zero
// - Skip when memory byte is nonzero
// - Skip when selected bit is one
// - Direct full address, no bank select
module erss_core import erss_pkg::*; #(
	parameter int unsigned MEM_DEPTH = ERSS_MEM_DEPTH
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ERSS_PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Engine status
	output logic BUSY,
	output logic SKIP,
	output logic DONE
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_EXEC = 2'b10,
		ST_DUMMY = 2'b11
	} erss_state_e;

	erss_state_e state;
	erss_state_e next_state;
	logic [7:0] mem [0:MEM_DEPTH-1];
	erss_cmd_s cmd;
	logic [7:0] operand;
	logic [7:0] acc;
	erss_flags_s flags;
	logic [15:0] pc;
	logic [8:0] maddr;
	logic last_skip;
	logic [1:0] last_cycles;
	erss_res_s res;

	logic setup;
	logic access;
	logic wr_acc;
	logic rd_setup;
	logic err;
	logic busy_now;
	logic cmd_start;
	logic [3:0] wr_op;
	logic sel_cmd;
	logic sel_acc;
	logic sel_flags;
	logic sel_state;
	logic sel_pc;
	logic sel_maddr;
	logic sel_mdata;
	logic wr_accum;
	logic wr_flags;
	logic wr_pc;
	logic wr_maddr;
	logic wr_mdata;
	logic exec_now;
	logic dummy_now;
	logic eng_wr_mem;
	logic eng_wr_acc;
	logic [31:0] next_prdata;
	logic [7:0] next_acc;
	erss_flags_s next_flags;
	logic [15:0] next_pc;

	// Address decode, used only by the error response; the read mux uses the sel_ decodes
	function automatic logic reg_mapped(input logic [ERSS_PADDR_W-1:0] a);
		if (a == ERSS_OFF_CMD) begin
			reg_mapped = 1'b1;
		end else if (a == ERSS_OFF_ACC) begin
			reg_mapped = 1'b1;
		end else if (a == ERSS_OFF_FLAGS) begin
			reg_mapped = 1'b1;
		end else if (a == ERSS_OFF_STATE) begin
			reg_mapped = 1'b1;
		end else if (a == ERSS_OFF_PC) begin
			reg_mapped = 1'b1;
		end else if (a == ERSS_OFF_MADDR) begin
			reg_mapped = 1'b1;
		end else if (a == ERSS_OFF_MDATA) begin
			reg_mapped = 1'b1;
		end else begin
			reg_mapped = 1'b0;
		end
	endfunction : reg_mapped

	assign setup = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE;
	assign rd_setup = setup & ~PWRITE;
	assign busy_now = (state != ST_IDLE);
	assign wr_op = PWDATA[ERSS_CMD_OP_LSB +: 4];

	// Register selects, decoded once for the read mux and the write strobes
	assign sel_cmd = (PADDR == ERSS_OFF_CMD);
	assign sel_acc = (PADDR == ERSS_OFF_ACC);
	assign sel_flags = (PADDR == ERSS_OFF_FLAGS);
	assign sel_state = (PADDR == ERSS_OFF_STATE);
	assign sel_pc = (PADDR == ERSS_OFF_PC);
	assign sel_maddr = (PADDR == ERSS_OFF_MADDR);
	assign sel_mdata = (PADDR == ERSS_OFF_MDATA);

	// Access error: any unmapped access; on writes also read-only, engine busy, or unknown opcode
	always_comb begin
		err = 1'b0;
		if (!reg_mapped(PADDR)) begin
			err = 1'b1;
		end else if (PWRITE && (PADDR == ERSS_OFF_STATE)) begin
			err = 1'b1;
		end else if (PWRITE && busy_now) begin
			err = 1'b1;
		end else if (PWRITE && (PADDR == ERSS_OFF_CMD) && (wr_op > ERSS_OP_LAST)) begin
			err = 1'b1;
		end
	end

	// Read data is captured in the setup cycle, so no wait states
	assign PREADY = access;
	assign PSLVERR = access & err;
	assign wr_acc = access & PWRITE & ~err;
	assign cmd_start = wr_acc & sel_cmd;
	assign BUSY = busy_now;
	assign SKIP = dummy_now;

	// Accepted software writes; none can land while the engine is busy
	assign wr_accum = wr_acc & sel_acc;
	assign wr_flags = wr_acc & sel_flags;
	assign wr_pc = wr_acc & sel_pc;
	assign wr_maddr = wr_acc & sel_maddr;
	assign wr_mdata = wr_acc & sel_mdata;

	// Engine memory and accumulator writes land only at the end of the execute cycle
	assign exec_now = (state == ST_EXEC);
	assign dummy_now = (state == ST_DUMMY);
	assign eng_wr_mem = exec_now & res.wr_mem;
	assign eng_wr_acc = exec_now & res.wr_acc;

	// Read mux; unmapped addresses read as zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (sel_cmd) begin
			next_prdata[ERSS_CMD_OP_LSB +: 4] = cmd.op;
			next_prdata[ERSS_CMD_BIT_LSB +: 3] = cmd.bit_sel;
			next_prdata[ERSS_CMD_ADDR_LSB +: 9] = cmd.addr;
		end else if (sel_acc) begin
			next_prdata[7:0] = acc;
		end else if (sel_flags) begin
			next_prdata[5:0] = flags;
		end else if (sel_state) begin
			next_prdata[ERSS_ST_BUSY] = busy_now;
			next_prdata[ERSS_ST_SKIP] = last_skip;
			next_prdata[ERSS_ST_CYC_LSB +: 2] = last_cycles;
		end else if (sel_pc) begin
			next_prdata[15:0] = pc;
		end else if (sel_maddr) begin
			next_prdata[8:0] = maddr;
		end else if (sel_mdata) begin
			next_prdata[7:0] = mem[maddr];
		end
	end

	// Loaded only at a read setup, so it stands through the access phase
	always_ff @(posedge CLK) begin
		if (RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (rd_setup) begin
			PRDATA <= next_prdata;
		end
	end

	// Command register; the full nine-bit address reaches any section
	always_ff @(posedge CLK) begin
		if (RST) begin
			cmd <= '0;
		end else if (cmd_start) begin
			cmd.op <= erss_op_e'(wr_op);
			cmd.bit_sel <= PWDATA[ERSS_CMD_BIT_LSB +: 3];
			cmd.addr <= PWDATA[ERSS_CMD_ADDR_LSB +: 9];
		end
	end

	// Sequencer: fetch operand, execute, then a dummy cycle when skipping
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (cmd_start) begin
					next_state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				next_state = ST_EXEC;
			end
			ST_EXEC: begin
				if (res.skip) begin
					next_state = ST_DUMMY;
				end else begin
					next_state = ST_IDLE;
				end
			end
			ST_DUMMY: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Operand read straight from the array, no bank register in the path
	always_ff @(posedge CLK) begin
		if (RST) begin
			operand <= 8'h00;
		end else if (state == ST_FETCH) begin
			operand <= mem[cmd.addr];
		end
	end

	erss_alu u_alu (
		.op(cmd.op),
		.bit_sel(cmd.bit_sel),
		.mem(operand),
		.acc(acc),
		.flags(flags),
		.res(res)
	);

	// Memory: engine writes only while busy, software only while idle
	always_ff @(posedge CLK) begin
		if (eng_wr_mem) begin
			mem[cmd.addr] <= res.value;
		end else if (wr_mdata) begin
			mem[maddr] <= PWDATA[7:0];
		end
	end

	always_comb begin
		next_acc = acc;
		if (eng_wr_acc) begin
			next_acc = res.value;
		end else if (wr_accum) begin
			next_acc = PWDATA[7:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			acc <= ERSS_ACC_RST;
		end else begin
			acc <= next_acc;
		end
	end

	// Skip forms pass flags through unchanged from the datapath
	always_comb begin
		next_flags = flags;
		if (exec_now) begin
			next_flags = res.flags;
		end else if (wr_flags) begin
			next_flags = PWDATA[5:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			flags <= ERSS_FLAGS_RST;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			maddr <= ERSS_MADDR_RST;
		end else if (wr_maddr) begin
			maddr <= PWDATA[8:0];
		end
	end

	// Program counter passes over the skipped instruction in the dummy cycle
	always_comb begin
		next_pc = pc;
		if (exec_now || dummy_now) begin
			next_pc = pc + 16'h0001;
		end else if (wr_pc) begin
			next_pc = PWDATA[15:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			pc <= ERSS_PC_RST;
		end else begin
			pc <= next_pc;
		end
	end

	// Outcome of the last command, kept until the execute cycle of the next one
	always_ff @(posedge CLK) begin
		if (RST) begin
			last_skip <= 1'b0;
			last_cycles <= 2'h0;
		end else if (state == ST_EXEC) begin
			last_skip <= res.skip;
			last_cycles <= res.skip ? ERSS_CYC_SKIP : ERSS_CYC_PLAIN;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			DONE <= 1'b0;
		end else begin
			DONE <= busy_now && (next_state == ST_IDLE);
		end
	end

endmodule : erss_core

/* sim/erss_core_sva.sv */
// Port-level checks for the extended rotate / subtract / skip engine.
// Assumes one clock CLK with synchronous active-high RST; bound to erss_core.
`timescale 1ns/1ps
module erss_core_sva import erss_pkg::*; (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ERSS_PADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Status
	input wire logic BUSY,
	input wire logic SKIP,
	input wire logic DONE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY)
		else $error("ready missing in access phase");
	a_err_access_only: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("error flag outside access phase");
	a_err_unmapped: assert property (PSEL && PENABLE && PADDR > 8'h18 |-> PSLVERR)
		else $error("unmapped access not refused");
	a_err_busy_write: assert property (PSEL && PENABLE && PWRITE && BUSY |-> PSLVERR)
		else $error("write while busy not refused");
	a_cmd_starts_busy: assert property (PSEL && PENABLE && PWRITE
		&& PADDR == ERSS_OFF_CMD && !BUSY && PWDATA[3:0] != 4'hF |=> BUSY)
		else $error("command did not start");
	a_busy_span: assert property ($rose(BUSY) |-> !SKIP ##1 (BUSY && !SKIP)
		##1 ((!BUSY) or (SKIP ##1 !BUSY)))
		else $error("busy span not two or three cycles");
	a_skip_single: assert property (SKIP |-> BUSY ##1 !SKIP)
		else $error("dummy cycle not single");
	a_done_follows: assert property ($fell(BUSY) |-> DONE)
		else $error("done missing after busy");
	a_done_cause: assert property (DONE |-> !BUSY && $past(BUSY))
		else $error("done without finished command");
endmodule : erss_core_sva

bind erss_core erss_core_sva u_sva (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .BUSY(BUSY), .SKIP(SKIP), .DONE(DONE));

/* sim/erss_core_tb.sv */
// Self-checking bench for erss_core: loads operands over APB, runs each op, reads back.
// Assumes the checker is bound from its own file; 50 MHz clock, zero-wait APB slave.
`timescale 1ns/1ps
module erss_core_tb import erss_pkg::*;;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA, rd;
	logic PREADY, PSLVERR, BUSY, SKIP, DONE, er;
	logic [31:0] x = 32'h38;
	int fails = 0;
	int compares = 0;

	always #10 CLK = ~CLK;

	erss_core u_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.BUSY(BUSY), .SKIP(SKIP), .DONE(DONE));

	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : rnd

	// Returns {mem, acc, flags, skip}
	function automatic logic [22:0] model(input logic [3:0] op, input logic [2:0] b,
		input logic [7:0] m, input logic [7:0] a, input logic [5:0] f);
		logic [8:0] d;
		logic [7:0] nm, na;
		logic [5:0] nf;
		logic s, v;
		nm = m;
		na = a;
		nf = f;
		s = 1'b0;
		d = {1'b0, a} - {1'b0, m} - {8'h00, ~f[0]};
		v = (a[7] ^ m[7]) & (a[7] ^ d[7]);
		case (op)
			4'h0: begin na = {m[6:0], f[0]}; nf[0] = m[7]; end
			4'h1: nm = {m[0], m[7:1]};
			4'h2: na = {m[0], m[7:1]};
			4'h3: begin nm = {f[0], m[7:1]}; nf[0] = m[0]; end
			4'h4: begin na = {f[0], m[7:1]}; nf[0] = m[0]; end
			4'h5, 4'h6: begin
				nf = {(d[7:0] == 8'h00) & f[2], d[7] ^ v, v, d[7:0] == 8'h00,
					{1'b0, a[3:0]} >= {1'b0, m[3:0]} + {4'h0, ~f[0]}, ~d[8]};
				if (op == 4'h5) na = d[7:0];
				else nm = d[7:0];
			end
			4'h7: begin nm = m - 8'h01; s = nm == 8'h00; end
			4'h8: begin na = m - 8'h01; s = na == 8'h00; end
			4'h9: nm = 8'hFF;
			4'hA: nm = m | (8'h01 << b);
			4'hB: begin nm = m + 8'h01; s = nm == 8'h00; end
			4'hC: begin na = m + 8'h01; s = na == 8'h00; end
			4'hD: s = m != 8'h00;
			default: s = m[b];
		endcase
		return {nm, na, nf, s};
	endfunction : model

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= ad;
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1) @(posedge CLK);
		rd = PRDATA;
		er = PSLVERR;
		PENABLE <= 1'b0;
	endtask : apb

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (fails == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// Hang guard, far beyond the few thousand cycles needed
	initial begin
		#400000;
		fails++;
		tally_and_finish();
	end

	initial begin
		logic [22:0] e;
		logic [7:0] m, a;
		logic [5:0] f;
		logic [3:0] op;
		logic [2:0] b;
		logic [8:0] ad;
		logic [31:0] r, pc;
		repeat (20) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, ERSS_OFF_STATE, 32'h1);
		chk("state write err", {31'h0, er}, 32'h1);
		apb(1'b1, ERSS_OFF_CMD, 32'hF);
		chk("bad op err", {31'h0, er}, 32'h1);
		// First 45 runs: every op with 01, FF and 00 operands for skip edges
		for (int i = 0; i < 100; i++) begin
			r = rnd();
			op = (i < 45) ? 4'(i % 15) : 4'(r[3:0] % 4'hF);
			b = r[6:4];
			ad = r[16:8];
			a = r[24:17];
			f = r[30:25];
			r = rnd();
			m = (i < 15) ? 8'h01 : (i < 30) ? 8'hFF : (i < 45) ? 8'h00 : r[7:0];
			apb(1'b1, ERSS_OFF_MADDR, {23'h0, ad});
			apb(1'b1, ERSS_OFF_MDATA, {24'h0, m});
			apb(1'b1, ERSS_OFF_MADDR, {23'h0, ~ad});
			apb(1'b1, ERSS_OFF_ACC, {24'h0, a});
			apb(1'b1, ERSS_OFF_FLAGS, {26'h0, f});
			apb(1'b0, ERSS_OFF_PC, 32'h0);
			pc = rd;
			apb(1'b1, ERSS_OFF_CMD, {15'h0, ad, 1'b0, b, op});
			chk("cmd err", {31'h0, er}, 32'h0);
			apb(1'b1, ERSS_OFF_ACC, {24'h0, ~a});
			chk("busy write err", {31'h0, er}, 32'h1);
			rd = 32'h1;
			for (int t = 0; t < 8; t++) if (rd[0] !== 1'b0) apb(1'b0, ERSS_OFF_STATE, 32'h0);
			e = model(op, b, m, a, f);
			apb(1'b1, ERSS_OFF_MADDR, {23'h0, ad});
			apb(1'b0, ERSS_OFF_MDATA, 32'h0);
			chk("mem", rd, {24'h0, e[22:15]});
			apb(1'b0, ERSS_OFF_ACC, 32'h0);
			chk("acc", rd, {24'h0, e[14:7]});
			apb(1'b0, ERSS_OFF_FLAGS, 32'h0);
			chk("flags", rd, {26'h0, e[6:1]});
			apb(1'b0, ERSS_OFF_STATE, 32'h0);
			chk("state", rd, {26'h0, e[0] ? 2'h2 : 2'h1, 2'h0, e[0], 1'b0});
			apb(1'b0, ERSS_OFF_PC, 32'h0);
			chk("pc", rd, 32'((pc + (e[0] ? 32'h2 : 32'h1)) & 32'hFFFF));
		end
		PSEL <= 1'b0;
		@(posedge CLK);
		tally_and_finish();
	end
endmodule : erss_core_tb
